/* rtl/irc_pin_edge.sv */
// synchroniser and selectable edge detector for the external request pin
// assumes pin is asynchronous to clk
module irc_pin_edge (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       pin,
	input  wire logic [1:0] edge_select,
	output logic            edge_event
);
	logic sync1_reg;
	logic sync2_reg;
	logic prev_reg;
	logic event_reg;
	wire  rise_seen = sync2_reg & ~prev_reg;
	wire  fall_seen = ~sync2_reg & prev_reg;
	wire  event_next = (edge_select[0] & rise_seen) | (edge_select[1] & fall_seen);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			prev_reg  <= 1'b0;
			event_reg <= 1'b0;
		end else begin
			sync1_reg <= pin;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
			event_reg <= event_next;
		end
	end

	assign edge_event = event_reg;
endmodule

/* rtl/irc_pkg.sv */
// constants shared by the interrupt request control block
// assumes an 8-bit special-purpose data memory port from the core
package irc_pkg;
	localparam logic [7:0] ADDR_EDGE_CONFIG  = 8'h0a;
	localparam logic [7:0] ADDR_PRIMARY_CTRL = 8'h0b;
	localparam logic [7:0] ADDR_CONV_CTRL    = 8'h0c;

	localparam logic [7:0] RST_EDGE_CONFIG   = 8'h00;
	localparam logic [7:0] RST_PRIMARY_CTRL  = 8'h00;
	localparam logic [7:0] RST_CONV_CTRL     = 8'h00;

	localparam int BIT_EDGE_SEL_LO  = 0;
	localparam int BIT_EDGE_SEL_HI  = 1;
	localparam int BIT_TMR_FLAG     = 6;
	localparam int BIT_TICK_FLAG    = 5;
	localparam int BIT_EXT_FLAG     = 4;
	localparam int BIT_TMR_EN       = 3;
	localparam int BIT_TICK_EN      = 2;
	localparam int BIT_EXT_EN       = 1;
	localparam int BIT_GLOBAL_EN    = 0;
	localparam int BIT_CONV_FLAG    = 4;
	localparam int BIT_CONV_EN      = 0;

	localparam logic [1:0] EDGE_OFF     = 2'h0;
	localparam logic [1:0] EDGE_RISE    = 2'h1;
	localparam logic [1:0] EDGE_FALL    = 2'h2;
	localparam logic [1:0] EDGE_BOTH    = 2'h3;

	// source index, also the order of priority (0 highest)
	localparam logic [1:0] SRC_EXT      = 2'h0;
	localparam logic [1:0] SRC_TMR      = 2'h1;
	localparam logic [1:0] SRC_TICK     = 2'h2;
	localparam logic [1:0] SRC_CONV     = 2'h3;
endpackage

/* rtl/irc_top.sv */
// interrupt request control: flags, enables, edge config and request to the core
// assumes a one-cycle special-purpose data memory port and same-clock peripheral pulses
module irc_top (
	input  wire logic       CORE_CLK,
	input  wire logic       RST_N,
	input  wire logic [7:0] SFR_ADDR,
	input  wire logic       SFR_WR,
	input  wire logic [7:0] SFR_WDATA,
	output logic      [7:0] SFR_RDATA,
	input  wire logic       EXT_PIN,
	input  wire logic       TMR_EVENT,
	input  wire logic       TICK_EVENT,
	input  wire logic       CONV_EVENT,
	input  wire logic       IRQ_ACK,
	output logic            IRQ_REQ,
	output logic      [1:0] IRQ_SRC
);
	logic [1:0] edge_select_reg;
	logic       global_irq_enable_reg;
	logic [3:0] flag_reg;
	logic [3:0] enable_reg;
	logic [7:0] rdata_reg;
	logic       irq_reg;
	logic [1:0] src_reg;
	logic       ext_edge_event;

	irc_pin_edge u_pin_edge (
		.clk         (CORE_CLK),
		.rst_n       (RST_N),
		.pin         (EXT_PIN),
		.edge_select (edge_select_reg),
		.edge_event  (ext_edge_event)
	);

	// decode of the three registers
	wire wr_edge = SFR_WR && (SFR_ADDR == irc_pkg::ADDR_EDGE_CONFIG);
	wire wr_prim = SFR_WR && (SFR_ADDR == irc_pkg::ADDR_PRIMARY_CTRL);
	wire wr_conv = SFR_WR && (SFR_ADDR == irc_pkg::ADDR_CONV_CTRL);

	// source events indexed by source number
	wire [3:0] src_event = {CONV_EVENT, TICK_EVENT, TMR_EVENT, ext_edge_event};

	// software view of flags and enables, by source number
	wire [3:0] wr_flag_val = {SFR_WDATA[irc_pkg::BIT_CONV_FLAG], SFR_WDATA[irc_pkg::BIT_TICK_FLAG],
	                          SFR_WDATA[irc_pkg::BIT_TMR_FLAG], SFR_WDATA[irc_pkg::BIT_EXT_FLAG]};
	wire [3:0] wr_en_val   = {SFR_WDATA[irc_pkg::BIT_CONV_EN], SFR_WDATA[irc_pkg::BIT_TICK_EN],
	                          SFR_WDATA[irc_pkg::BIT_TMR_EN], SFR_WDATA[irc_pkg::BIT_EXT_EN]};
	wire [3:0] wr_sel      = {wr_conv, wr_prim, wr_prim, wr_prim};

	// service acknowledge clears the flag of the presented source
	wire [3:0] ack_clear   = (IRQ_ACK && irq_reg) ? (4'h1 << src_reg) : 4'h0;

	logic [3:0] flag_next;
	logic [3:0] enable_next;
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_src
			// event wins over any clear in the same cycle
			assign flag_next[i]   = src_event[i] |
			                        (wr_sel[i] ? wr_flag_val[i] : (flag_reg[i] & ~ack_clear[i]));
			assign enable_next[i] = wr_sel[i] ? wr_en_val[i] : enable_reg[i];
		end
	endgenerate

	wire service = IRQ_ACK && irq_reg;
	wire global_next = service ? 1'b0 :
	                   (wr_prim ? SFR_WDATA[irc_pkg::BIT_GLOBAL_EN] : global_irq_enable_reg);
	wire [1:0] edge_next = wr_edge ? SFR_WDATA[1:0] : edge_select_reg;

	wire [3:0] armed   = flag_next & enable_next;
	wire       irq_next = global_next && (armed != 4'h0);
	wire [1:0] src_next = armed[0] ? irc_pkg::SRC_EXT :
	                      armed[1] ? irc_pkg::SRC_TMR :
	                      armed[2] ? irc_pkg::SRC_TICK : irc_pkg::SRC_CONV;

	// read views of the registers
	wire [7:0] edge_view = {6'h00, edge_select_reg};
	wire [7:0] prim_view = {1'b0, flag_reg[1], flag_reg[2], flag_reg[0],
	                        enable_reg[1], enable_reg[2], enable_reg[0], global_irq_enable_reg};
	wire [7:0] conv_view = {3'h0, flag_reg[3], 3'h0, enable_reg[3]};
	wire [7:0] rdata_next = (SFR_ADDR == irc_pkg::ADDR_EDGE_CONFIG)  ? edge_view :
	                        (SFR_ADDR == irc_pkg::ADDR_PRIMARY_CTRL) ? prim_view :
	                        (SFR_ADDR == irc_pkg::ADDR_CONV_CTRL)    ? conv_view : 8'h00;

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			edge_select_reg       <= irc_pkg::RST_EDGE_CONFIG[1:0];
			global_irq_enable_reg <= irc_pkg::RST_PRIMARY_CTRL[irc_pkg::BIT_GLOBAL_EN];
			flag_reg              <= 4'h0;
			enable_reg            <= 4'h0;
			rdata_reg             <= 8'h00;
			irq_reg               <= 1'b0;
			src_reg               <= irc_pkg::SRC_EXT;
		end else begin
			edge_select_reg       <= edge_next;
			global_irq_enable_reg <= global_next;
			flag_reg              <= flag_next;
			enable_reg            <= enable_next;
			rdata_reg             <= rdata_next;
			irq_reg               <= irq_next;
			src_reg               <= src_next;
		end
	end

	assign SFR_RDATA = rdata_reg;
	assign IRQ_REQ   = irq_reg;
	assign IRQ_SRC   = src_reg;
endmodule

/* verification/irc_checker.sv */
// port assertions for irc_top
// assumes registers at 0a to 0c and a one-edge read port
module irc_checker (
	input wire logic       CORE_CLK,
	input wire logic       RST_N,
	input wire logic [7:0] SFR_ADDR,
	input wire logic       SFR_WR,
	input wire logic [7:0] SFR_WDATA,
	input wire logic [7:0] SFR_RDATA,
	input wire logic       TMR_EVENT,
	input wire logic       IRQ_ACK,
	input wire logic       IRQ_REQ,
	input wire logic [1:0] IRQ_SRC
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_N);
	AST_ACK: assert property (IRQ_ACK && IRQ_REQ |=> !IRQ_REQ) else $error("req after ack");
	AST_ACK_GLB: assert property (IRQ_ACK && IRQ_REQ ##1 SFR_ADDR == 8'h0b |=> !SFR_RDATA[0]) else $error("glb");
	AST_GLB_OFF: assert property (SFR_WR && SFR_ADDR == 8'h0b && !SFR_WDATA[0] |=> !IRQ_REQ) else $error("glb off");
	AST_TMR: assert property (TMR_EVENT ##1 SFR_ADDR == 8'h0b |=> SFR_RDATA[6]) else $error("tmr flag");
	AST_EDGE_RD: assert property (SFR_ADDR == 8'h0a |=> SFR_RDATA[7:2] == 6'h00) else $error("edge bits");
	AST_CONV_RD: assert property (SFR_ADDR == 8'h0c |=> (SFR_RDATA & 8'hee) == 8'h00) else $error("conv bits");
	AST_UNMAP: assert property (SFR_ADDR < 8'h0a || SFR_ADDR > 8'h0c |=> SFR_RDATA == 8'h00) else $error("unmap");
	AST_STICK: assert property (IRQ_REQ && !IRQ_ACK && !SFR_WR |=> IRQ_REQ) else $error("req dropped");
	cover property (IRQ_ACK && IRQ_REQ);
	cover property (IRQ_REQ && IRQ_SRC == 2'h0);
	cover property (IRQ_REQ && IRQ_SRC == 2'h3);
endmodule

bind irc_top irc_checker irc_checker_inst (.CORE_CLK, .RST_N, .SFR_ADDR, .SFR_WR, .SFR_WDATA, .SFR_RDATA,
	.TMR_EVENT, .IRQ_ACK, .IRQ_REQ, .IRQ_SRC);

/* verification/irc_core_model.sv */
// core stand-in that services presented requests
// assumes request and ack share the block clock
module irc_core_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic go,
	input  wire logic irq_req,
	output logic      irq_ack
);
	timeunit 1ns;
	timeprecision 1ns;
	// one ack per request, slow when go is low
	always @(posedge clk) irq_ack <= rst_n && go && irq_req && !irq_ack;
endmodule

/* verification/test_irc_top.sv */
// random bench for irc_top checked against a cycle model
// assumes the bound checker and irc_core_model
module test_irc_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic       CORE_CLK = 0, RST_N = 0, SFR_WR = 0, EXT_PIN = 0, go = 0, IRQ_ACK, IRQ_REQ;
	logic       TMR_EVENT = 0, TICK_EVENT = 0, CONV_EVENT = 0;
	logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, SFR_RDATA, ad;
	logic [1:0] IRQ_SRC;
	int         fails = 0, tests_run = 0, p, c, e, h, rd, rq, s, k;
	always #25 CORE_CLK = ~CORE_CLK;
	irc_top irc_top_inst (.CORE_CLK, .RST_N, .SFR_ADDR, .SFR_WR, .SFR_WDATA, .SFR_RDATA, .EXT_PIN,
		.TMR_EVENT, .TICK_EVENT, .CONV_EVENT, .IRQ_ACK, .IRQ_REQ, .IRQ_SRC);
	irc_core_model irc_core_model_inst (.clk(CORE_CLK), .rst_n(RST_N), .go, .irq_req(IRQ_REQ), .irq_ack(IRQ_ACK));
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		tests_run++;
		if (seen !== want) begin
			fails++;
			$display("unexpected at %0t: %h vs %h", $time, seen, want);
		end
	endtask
	task automatic wrap_up;
		if (fails == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic cyc(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [3:0] ev);
		@(posedge CORE_CLK);
		SFR_ADDR <= a;
		SFR_WR <= w;
		SFR_WDATA <= d;
		{EXT_PIN, TMR_EVENT, TICK_EVENT, CONV_EVENT} <= ev;
		go <= $urandom % 3 != 0;
	endtask
	// reference model: read shows registers from before the edge
	always @(posedge CORE_CLK) begin
		rd = SFR_ADDR == 8'h0a ? e : SFR_ADDR == 8'h0b ? p : SFR_ADDR == 8'h0c ? c : 0;
		// a software write of a flag wins over the service clear of that flag
		if (IRQ_ACK && rq) p = p & ~(s == 0 ? 17 : s == 1 ? 65 : s == 2 ? 33 : 1);
		if (IRQ_ACK && rq && s == 3) c = c & 1;
		if (SFR_WR && SFR_ADDR == 8'h0a) e = SFR_WDATA & 3;
		if (SFR_WR && SFR_ADDR == 8'h0b) p = SFR_WDATA & 8'h7f;
		if (SFR_WR && SFR_ADDR == 8'h0c) c = SFR_WDATA & 8'h11;
		// the service clear of the global enable wins over a write
		if (IRQ_ACK && rq) p = p & ~1;
		if (((e & 1) && h[2] && !h[3]) || ((e & 2) && !h[2] && h[3])) p = p | 16;
		p = p | TMR_EVENT << 6 | TICK_EVENT << 5;
		c = c | CONV_EVENT << 4;
		h = (h << 1 | EXT_PIN) & 15;
		if (!RST_N) p = 0;
		if (!RST_N) c = 0;
		if (!RST_N) e = 0;
		k = p & p >> 3;
		rq = (p & 1) && ((k & 14) || (c & c >> 4 & 1));
		s = k & 2 ? 0 : k & 8 ? 1 : k & 4 ? 2 : 3;
	end
	always @(negedge CORE_CLK) if (RST_N) begin
		check(SFR_RDATA, 8'(rd));
		check(8'(IRQ_REQ), 8'(rq));
		if (rq) check(8'(IRQ_SRC), 8'(s));
	end
	initial begin
		void'($urandom(8194));
		repeat (16) @(posedge CORE_CLK);
		RST_N <= 1;
		for (int m = 0; m < 4; m++) begin
			repeat (5) cyc(8'h0a, 0, 8'h00, {EXT_PIN, 3'h0});
			cyc(8'h0a, 1, 8'($urandom) & 8'hfc | 8'(m), {EXT_PIN, 3'h0});
			repeat (200) begin
				ad = 8'h08 + 8'($urandom % 6);
				cyc(ad, ad != 8'h0a && $urandom % 4 == 0, 8'($urandom), {EXT_PIN ^ ($urandom % 8 == 0), 3'($urandom & $urandom)});
			end
		end
		wrap_up();
	end
	initial begin
		#200000;
		fails++;
		wrap_up();
	end
endmodule
